/* File: synth_post_divider_map.svh */
/*
 * Register map, field positions, reset values and mode codes for the synthesizer
 * post divider and address paging block.
 * Assumes it is included by its bare name and that nothing else defines these macros.
 */
`ifndef SYNTH_POST_DIVIDER_MAP_SVH
`define SYNTH_POST_DIVIDER_MAP_SVH

// Full 8-bit register addresses.
`define ADDR_SYNTH1_PHASE_ADVANCE   8'h79
`define ADDR_ADDRESS_PAGE_SELECT    8'h7f
`define ADDR_SYNTH0_DIVIDER_A       8'h80
`define ADDR_SYNTH0_DIVIDER_B       8'h83
`define ADDR_SYNTH0_DIVIDER_C       8'h86

// Reset values.
`define RST_SYNTH1_PHASE_ADVANCE    8'h00
`define RST_ADDRESS_PAGE_SELECT     1'h0
`define RST_SYNTH0_DIVIDER_A        24'h000002
`define RST_SYNTH0_DIVIDER_B        24'h000002
`define RST_SYNTH0_DIVIDER_C        24'h000040

// Serial address width and the page bit position.
`define SERIAL_ADDR_WIDTH           7
`define PAGE_SELECT_BIT             0

// Fine phase advance step count per synthesizer period.
`define PHASE_ADVANCE_STEPS         256

// Divider A and B ratio field.
`define RATIO_AB_MSB                22

// Divider C fields.
`define DIVC_MODE_MSB               23
`define DIVC_MODE_LSB               20
`define DIVC_MODE_FRAME_PULSE       4'hf
`define DIVC_PULSE_TYPE_BIT         19
`define DIVC_POLARITY_BIT           18
`define DIVC_REL_SEL_MSB            17
`define DIVC_REL_SEL_LSB            16
`define DIVC_PERIOD_MSB             15

// Smallest ratio the divider can realise from the system clock.
`define MIN_RATIO                   24'h000002

`endif

/* File: synth_post_divider_pkg.sv */
/*
 * Types shared by the post divider block.
 * Assumes synth_post_divider_map.svh supplies the numeric constants.
 */
package synth_post_divider_pkg;

  typedef enum logic [1:0] {
    rel_clock_a        = 2'h0,
    rel_clock_b        = 2'h1,
    rel_clock_reserved = 2'h2,
    rel_clock_d        = 2'h3
  } rel_sel_type;

  typedef enum logic {
    pulse_centred,
    pulse_edge
  } pulse_type_type;

endpackage

/* File: clk_ratio_divider.sv */
/*
 * Integer ratio clock divider with a near 50% duty cycle, run on the system clock.
 * Assumes the ratio input is quasi-static; a new ratio acts at once on the count in progress.
 */
`timescale 1ns/1ps
`include "synth_post_divider_map.svh"

module clk_ratio_divider #(
  parameter int WIDTH = 24
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] ratio,
  output logic                  clk_out
);

  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             next_clk_out;
  logic [WIDTH-1:0] eff_ratio;
  logic [WIDTH:0]   high_len;

  ////////////////////////////////////////////////////////////////////////////////
  // Even ratios give exactly half high; odd ratios give one extra high cycle, so
  // small odd ratios stray from 50%, as on the real synthesizer path.
  always_comb begin
    eff_ratio = (ratio < WIDTH'(`MIN_RATIO)) ? WIDTH'(`MIN_RATIO) : ratio;
    high_len  = ({1'b0, eff_ratio} + (WIDTH+1)'(1)) >> 1;
    if (count >= eff_ratio - WIDTH'(1)) begin
      next_count = '0;
    end else begin
      next_count = count + WIDTH'(1);
    end
    next_clk_out = ({1'b0, next_count} < high_len);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count   <= '0;
      clk_out <= 1'b0;
    end else begin
      count   <= next_count;
      clk_out <= next_clk_out;
    end
  end

endmodule // clk_ratio_divider

/* File: synth_post_divider_paging.sv */
/*
 * Configuration registers for synthesizer 1 fine phase advance, address paging and
 * the synthesizer 0 post dividers A, B and C, with divider C clock or frame pulse.
 * Assumes a serial front end (SPI or I2C) already decoded each access into a
 * 7-bit address, one write or read strobe and a data byte, all synchronous to
 * clk_sys, and that clk_sys stands in for the synthesizer 0 VCO.
 */
`timescale 1ns/1ps
`include "synth_post_divider_map.svh"

module synth_post_divider_paging (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       clk_in_d,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  output logic      [7:0] phase_advance_value,
  output logic            page_select,
  output logic            clk_out_a,
  output logic            clk_out_b,
  output logic            clk_out_c
);

  logic [23:0] ratio_a;
  logic [23:0] ratio_b;
  logic [23:0] ratio_c;
  logic [7:0]  next_phase_advance_value;
  logic        next_page_select;
  logic [23:0] next_ratio_a;
  logic [23:0] next_ratio_b;
  logic [23:0] next_ratio_c;
  logic [7:0]  next_reg_rdata;
  logic [7:0]  full_addr;

  ////////////////////////////////////////////////////////////////////////////////
  // Register file. Multi-byte registers put bits 23:16 at the lowest address.
  // The page register is decoded on its 7-bit address in either page so a host
  // can always get back to the low page.

  always_comb begin
    full_addr = {page_select, reg_addr};
    next_phase_advance_value = phase_advance_value;
    next_page_select         = page_select;
    next_ratio_a             = ratio_a;
    next_ratio_b             = ratio_b;
    next_ratio_c             = ratio_c;
    next_reg_rdata           = reg_rdata;
    if (reg_wr) begin
      if (reg_addr == 7'(`ADDR_ADDRESS_PAGE_SELECT)) begin
        next_page_select = reg_wdata[`PAGE_SELECT_BIT];
      end else if (full_addr == `ADDR_SYNTH1_PHASE_ADVANCE) begin
        next_phase_advance_value = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_A) begin
        next_ratio_a[23:16] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_A + 8'h01) begin
        next_ratio_a[15:8] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_A + 8'h02) begin
        next_ratio_a[7:0] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_B) begin
        next_ratio_b[23:16] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_B + 8'h01) begin
        next_ratio_b[15:8] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_B + 8'h02) begin
        next_ratio_b[7:0] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_C) begin
        next_ratio_c[23:16] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_C + 8'h01) begin
        next_ratio_c[15:8] = reg_wdata;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_C + 8'h02) begin
        next_ratio_c[7:0] = reg_wdata;
      end
    end
    if (reg_rd) begin
      if (reg_addr == 7'(`ADDR_ADDRESS_PAGE_SELECT)) begin
        next_reg_rdata = {7'h00, page_select};
      end else if (full_addr == `ADDR_SYNTH1_PHASE_ADVANCE) begin
        next_reg_rdata = phase_advance_value;
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_A) begin
        next_reg_rdata = ratio_a[23:16];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_A + 8'h01) begin
        next_reg_rdata = ratio_a[15:8];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_A + 8'h02) begin
        next_reg_rdata = ratio_a[7:0];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_B) begin
        next_reg_rdata = ratio_b[23:16];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_B + 8'h01) begin
        next_reg_rdata = ratio_b[15:8];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_B + 8'h02) begin
        next_reg_rdata = ratio_b[7:0];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_C) begin
        next_reg_rdata = ratio_c[23:16];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_C + 8'h01) begin
        next_reg_rdata = ratio_c[15:8];
      end else if (full_addr == `ADDR_SYNTH0_DIVIDER_C + 8'h02) begin
        next_reg_rdata = ratio_c[7:0];
      end else begin
        next_reg_rdata = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      phase_advance_value <= `RST_SYNTH1_PHASE_ADVANCE;
      page_select         <= `RST_ADDRESS_PAGE_SELECT;
      ratio_a             <= `RST_SYNTH0_DIVIDER_A;
      ratio_b             <= `RST_SYNTH0_DIVIDER_B;
      ratio_c             <= `RST_SYNTH0_DIVIDER_C;
      reg_rdata           <= 8'h00;
      reg_rvalid          <= 1'b0;
    end else begin
      phase_advance_value <= next_phase_advance_value;
      page_select         <= next_page_select;
      ratio_a             <= next_ratio_a;
      ratio_b             <= next_ratio_b;
      ratio_c             <= next_ratio_c;
      reg_rdata           <= next_reg_rdata;
      reg_rvalid          <= reg_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Post dividers. Bit 23 of A and B is ignored so a stray one cannot stretch the
  // ratio; the host is still expected to keep it zero.

  logic div_c_clock;

  clk_ratio_divider #(.WIDTH(24)) divider_a (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ratio   ({1'b0, ratio_a[`RATIO_AB_MSB:0]}),
    .clk_out (clk_out_a)
  );

  clk_ratio_divider #(.WIDTH(24)) divider_b (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ratio   ({1'b0, ratio_b[`RATIO_AB_MSB:0]}),
    .clk_out (clk_out_b)
  );

  clk_ratio_divider #(.WIDTH(24)) divider_c (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ratio   (ratio_c),
    .clk_out (div_c_clock)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Frame pulse generator. Frame boundaries fall on related-clock rising edges.
  // A centred pulse runs from the falling edge before the boundary to the one
  // after; an edge pulse runs from the boundary to the next rising edge.

  synth_post_divider_pkg::rel_sel_type    rel_sel;
  synth_post_divider_pkg::pulse_type_type pulse_type;
  logic        frame_mode;
  logic        rel_now;
  logic        rel_prev;
  logic        rel_rise;
  logic        rel_fall;
  logic [15:0] period_count;
  logic [15:0] next_period_count;
  logic [15:0] last_count;
  logic        pulse;
  logic        next_pulse;
  logic        next_clk_out_c;

  always_comb begin
    frame_mode = (ratio_c[`DIVC_MODE_MSB:`DIVC_MODE_LSB] == `DIVC_MODE_FRAME_PULSE);
    rel_sel    = synth_post_divider_pkg::rel_sel_type'(
                   ratio_c[`DIVC_REL_SEL_MSB:`DIVC_REL_SEL_LSB]);
    pulse_type = synth_post_divider_pkg::pulse_type_type'(ratio_c[`DIVC_PULSE_TYPE_BIT]);
    case (rel_sel)
      synth_post_divider_pkg::rel_clock_a: rel_now = clk_out_a;
      synth_post_divider_pkg::rel_clock_b: rel_now = clk_out_b;
      synth_post_divider_pkg::rel_clock_d: rel_now = clk_in_d;
      default:                             rel_now = 1'b0;
    endcase
    rel_rise   = rel_now & ~rel_prev;
    rel_fall   = ~rel_now & rel_prev;
    // A spacing of zero behaves as one so the counter never runs away.
    last_count = (ratio_c[`DIVC_PERIOD_MSB:0] == 16'h0000) ? 16'h0000
               : ratio_c[`DIVC_PERIOD_MSB:0] - 16'h0001;
    next_period_count = period_count;
    next_pulse        = pulse;
    // A reserved related-clock select has no edges, so the pulse is cleared here
    // rather than left frozen at whatever level it had when the select changed.
    if (!frame_mode || rel_sel == synth_post_divider_pkg::rel_clock_reserved) begin
      next_period_count = 16'h0000;
      next_pulse        = 1'b0;
    end else if (pulse_type == synth_post_divider_pkg::pulse_edge) begin
      if (rel_rise) begin
        next_period_count = (period_count >= last_count) ? 16'h0000
                          : period_count + 16'h0001;
        next_pulse        = (period_count >= last_count);
      end
    end else begin
      if (rel_rise) begin
        next_period_count = (period_count >= last_count) ? 16'h0000
                          : period_count + 16'h0001;
      end
      if (rel_fall) begin
        next_pulse = (period_count >= last_count);
      end
    end
    if (frame_mode) begin
      next_clk_out_c = next_pulse ^ ratio_c[`DIVC_POLARITY_BIT];
    end else begin
      next_clk_out_c = div_c_clock;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rel_prev     <= 1'b0;
      period_count <= 16'h0000;
      pulse        <= 1'b0;
      clk_out_c    <= 1'b0;
    end else begin
      rel_prev     <= rel_now;
      period_count <= next_period_count;
      pulse        <= next_pulse;
      clk_out_c    <= next_clk_out_c;
    end
  end

endmodule // synth_post_divider_paging

/* File: synth_post_divider_paging_checker.sv */
/* Port checker for the paging and post divider block.
   Assumes one-cycle strobes and a read answer one cycle after the strobe. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module synth_post_divider_paging_checker (
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic [7:0] phase_advance_value,
  input wire logic       page_select
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence phase_wr; reg_wr && !page_select && reg_addr == 7'h79; endsequence
  sequence page_wr; reg_wr && reg_addr == 7'h7f; endsequence
  sequence phase_rd; reg_rd && !page_select && reg_addr == 7'h79; endsequence
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe got no answer");
  a_valid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("answer without read strobe");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_page_write: assert property (page_wr |=> page_select == $past(reg_wdata[0]))
    else $error("page bit not taken from write");
  a_page_hold: assert property (!(reg_wr && reg_addr == 7'h7f) |=> $stable(page_select))
    else $error("page bit moved without write");
  a_page_read: assert property (reg_rd && reg_addr == 7'h7f |=>
      reg_rdata == {7'h00, $past(page_select)})
    else $error("page register read wrong");
  a_phase_write: assert property (phase_wr |=> phase_advance_value == $past(reg_wdata))
    else $error("phase advance not written");
  a_phase_hold: assert property (!(reg_wr && reg_addr == 7'h79) |=>
      $stable(phase_advance_value))
    else $error("phase advance moved without write");
  a_phase_read: assert property (phase_rd |=> reg_rdata == $past(phase_advance_value))
    else $error("phase advance read wrong");
endmodule // synth_post_divider_paging_checker

bind synth_post_divider_paging synth_post_divider_paging_checker synth_post_divider_paging_checker_i (
  .clk_sys(clk_sys), .rst_b(rst_b), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .phase_advance_value(phase_advance_value), .page_select(page_select));

/* File: host_reg_model.sv */
/* Host model issuing byte accesses on the decoded register port.
   Assumes the block samples strobes at the rising edge; this model drives at the falling one. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module host_reg_model (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [6:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
  end
  // Idle lines show the inverse of the last value so nothing leans on stale data.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    // The answer stands for one cycle only, so it is taken at the first falling
    // edge after the request was sampled.
    @(negedge clk_sys);
    ok = reg_rvalid;
    d = reg_rdata;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
  task automatic wr24(input logic [7:0] base, input logic [23:0] v);
    wr(7'h7f, {7'h00, base[7]});
    wr(base[6:0], v[23:16]);
    wr(base[6:0] + 7'h01, v[15:8]);
    wr(base[6:0] + 7'h02, v[7:0]);
  endtask
endmodule // host_reg_model

/* File: tb_synth_post_divider_paging.sv */
/* Self-checking bench for the paging and post divider block.
   Assumes the bound checker and the host model; clk_in_d is made here at a quarter rate. */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb_synth_post_divider_paging;
  logic       clk_sys, rst_b, reg_wr, reg_rd, reg_rvalid, page_select;
  logic       clk_in_d = 1'b0;
  logic       clk_out_a, clk_out_b, clk_out_c, mon;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, phase_advance_value;
  logic [1:0] dcnt = 2'h0;
  int         error_cnt, n_compared, cycles, sel;
  logic [7:0] rst_bytes [0:8] = '{8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h40};
  synth_post_divider_paging synth_post_divider_paging_i (.clk_sys(clk_sys), .rst_b(rst_b),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .clk_in_d(clk_in_d), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .phase_advance_value(phase_advance_value), .page_select(page_select),
    .clk_out_a(clk_out_a), .clk_out_b(clk_out_b), .clk_out_c(clk_out_c));
  host_reg_model host_reg_model_i (.clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(negedge clk_sys) begin
    dcnt <= dcnt + 2'h1;
    clk_in_d <= dcnt[1];
  end
  always_comb mon = (sel == 0) ? clk_out_a : (sel == 1) ? clk_out_b : clk_out_c;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      end_sim();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic chkn(input string nm, input int e, input int g);
    n_compared++;
    if (g != e) begin
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic rdc(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host_reg_model_i.rd(a, d, ok);
    chk8("read valid", 8'h01, {7'h00, ok});
    chk8("read data", e, d);
  endtask
  // One full high phase is captured, so the first partial one is skipped.
  task automatic mchk(input int k, input int eper, input int ehi);
    int n, per, hi;
    sel = k;
    n = 0;
    per = 0;
    hi = 0;
    @(negedge clk_sys);
    while (mon !== 1'b0 && n < 200) begin @(negedge clk_sys); n++; end
    while (mon !== 1'b1 && n < 200) begin @(negedge clk_sys); n++; end
    while (mon === 1'b1 && n < 200) begin @(negedge clk_sys); n++; hi++; per++; end
    while (mon !== 1'b1 && n < 200) begin @(negedge clk_sys); n++; per++; end
    chkn("high cycles", ehi, hi);
    if (eper > 0) chkn("period cycles", eper, per);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk8("phase port", 8'h00, phase_advance_value);
    chk8("page port", 8'h00, {7'h00, page_select});
    rdc(7'h79, 8'h00);
    rdc(7'h7f, 8'h00);
    mchk(0, 2, 1);
    mchk(1, 2, 1);
    mchk(2, 64, 32);
    $display("test reset done");
  endtask
  task automatic t_paging();
    host_reg_model_i.wr(7'h79, 8'ha5);
    chk8("phase port", 8'ha5, phase_advance_value);
    host_reg_model_i.wr(7'h7f, 8'hff);
    chk8("page port", 8'h01, {7'h00, page_select});
    host_reg_model_i.wr(7'h79, 8'h3c);
    chk8("phase port", 8'ha5, phase_advance_value);
    rdc(7'h79, 8'h00);
    rdc(7'h7f, 8'h01);
    for (int i = 0; i < 9; i++) rdc(i[6:0], rst_bytes[i]);
    host_reg_model_i.wr(7'h7f, 8'h00);
    rdc(7'h79, 8'ha5);
    $display("test paging done");
  endtask
  task automatic t_frame();
    logic [23:0] v [0:6] = '{24'hf80003, 24'hfc0003, 24'hf00003, 24'hf40003,
                             24'hfb0003, 24'hf90003, 24'hfa0003};
    int          ep [0:6] = '{6, 6, 6, 6, 12, 18, 0};
    int          eh [0:6] = '{2, 4, 2, 4, 4, 6, 0};
    host_reg_model_i.wr24(8'h83, 24'h000006);
    for (int i = 0; i < 7; i++) begin
      host_reg_model_i.wr24(8'h86, v[i]);
      repeat (30) @(negedge clk_sys);
      mchk(2, ep[i], eh[i]);
    end
    chk8("idle frame level", 8'h00, {7'h00, clk_out_c});
    $display("test frame done");
  endtask
  task automatic t_div();
    int          k [0:3] = '{0, 1, 2, 2};
    logic [7:0]  a [0:3] = '{8'h80, 8'h83, 8'h86, 8'h86};
    logic [23:0] v [0:3] = '{24'h000005, 24'h800006, 24'h000004, 24'h000007};
    int          ep [0:3] = '{5, 6, 4, 7};
    int          eh [0:3] = '{3, 3, 2, 4};
    for (int i = 0; i < 4; i++) begin
      host_reg_model_i.wr24(a[i], v[i] & 24'h7fffff);
      repeat (20) @(negedge clk_sys);
      mchk(k[i], ep[i], eh[i]);
    end
    $display("test divider done");
  endtask
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    sel = 0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    t_reset();
    t_paging();
    t_frame();
    t_div();
    end_sim();
  end
endmodule // tb_synth_post_divider_paging
